// [shared/cdgo_pkg.sv]
// Constants and helpers for the channel 2/3 digital gain and offset register bank
`default_nettype none
package cdgo_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	// Register indexes; byte address is four times the index
	localparam logic [5:0] CTRL_IDX = 6'h03;
	localparam logic [5:0] CH2_GAIN_OFFSET_IDX = 6'h0F;
	localparam logic [5:0] CH2_OFFSET_COPY_IDX = 6'h10;
	localparam logic [5:0] CH3_GAIN_OFFSET_IDX = 6'h11;
	localparam logic [5:0] CH3_OFFSET_COPY_IDX = 6'h12;
	localparam logic [5:0] STATUS_IDX = 6'h1F;
	// Field positions
	localparam int GAIN_MSB = 15;
	localparam int GAIN_LSB = 11;
	localparam int OFFSET_MSB = 9;
	localparam int OFFSET_LSB = 0;
	localparam int GAIN_EN_BIT = 12;
	localparam int OFFSET_EN_BIT = 8;
	localparam int ST_CH2_MISMATCH_BIT = 0;
	localparam int ST_CH3_MISMATCH_BIT = 1;
	// Reset values
	localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [REG_W-1:0] GAIN_OFFSET_RESET = 16'h0000;
	localparam logic [REG_W-1:0] OFFSET_COPY_RESET = 16'h0000;
	// Gain coefficient format: unsigned, 14 fraction bits
	localparam int COEF_W = 16;
	localparam int COEF_FRAC = 14;
	localparam logic [COEF_W-1:0] COEF_UNITY = 16'h4000;

	// Linear factor for N steps of 0.2 dB
	function automatic logic [COEF_W-1:0] gain_coef(input logic [4:0] steps);
		logic [COEF_W-1:0] c;
		c = COEF_UNITY;
		case (steps)
			5'd0: c = 16'h4000;
			5'd1: c = 16'h417E;
			5'd2: c = 16'h4304;
			5'd3: c = 16'h4494;
			5'd4: c = 16'h462D;
			5'd5: c = 16'h47CF;
			5'd6: c = 16'h497B;
			5'd7: c = 16'h4B31;
			5'd8: c = 16'h4CF2;
			5'd9: c = 16'h4EBD;
			5'd10: c = 16'h5092;
			5'd11: c = 16'h5273;
			5'd12: c = 16'h545F;
			5'd13: c = 16'h5656;
			5'd14: c = 16'h5858;
			5'd15: c = 16'h5A67;
			5'd16: c = 16'h5C82;
			5'd17: c = 16'h5EAA;
			5'd18: c = 16'h60DE;
			5'd19: c = 16'h6320;
			5'd20: c = 16'h656F;
			5'd21: c = 16'h67CC;
			5'd22: c = 16'h6A37;
			5'd23: c = 16'h6CB0;
			5'd24: c = 16'h6F38;
			5'd25: c = 16'h71CF;
			5'd26: c = 16'h7476;
			5'd27: c = 16'h772D;
			5'd28: c = 16'h79F3;
			5'd29: c = 16'h7CCA;
			5'd30: c = 16'h7FB2;
			5'd31: c = 16'h82AC;
			default: c = COEF_UNITY;
		endcase
		return c;
	endfunction
endpackage
`default_nettype wire

// [src/cdgo_chan_apply.sv]
// One channel of digital offset and gain applied to converter samples
`timescale 1ns/1ns
`default_nettype none
module cdgo_chan_apply #(
	parameter int SAMPLE_W = 14
) (
	input wire logic clk_i, // System clock
	input wire logic srst_i, // Synchronous reset, high
	input wire logic [4:0] gain_steps_i, // Gain in 0.2 dB steps
	input wire logic [9:0] offset_i, // Signed offset
	input wire logic gain_en_i, // Global gain enable
	input wire logic offset_en_i, // Global offset enable
	input wire logic signed [SAMPLE_W-1:0] data_i, // Sample in
	input wire logic valid_i, // Sample in valid
	output logic signed [SAMPLE_W-1:0] data_o, // Sample out
	output logic valid_o // Sample out valid
);
	import cdgo_pkg::*;

	localparam int SUM_W = SAMPLE_W + 1;
	localparam int PROD_W = SUM_W + COEF_W + 1;

	logic signed [SUM_W-1:0] offset_ext;
	logic signed [SUM_W-1:0] sum;
	logic [COEF_W-1:0] coef;
	logic signed [PROD_W-1:0] prod;
	logic signed [PROD_W-1:0] scaled;
	logic signed [SAMPLE_W-1:0] data_next;

	always_comb begin
		offset_ext = offset_en_i ? {{(SUM_W-10){offset_i[9]}}, offset_i} : '0;
		sum = {data_i[SAMPLE_W-1], data_i} + offset_ext;
		coef = gain_en_i ? gain_coef(gain_steps_i) : COEF_UNITY;
		prod = PROD_W'(sum) * $signed({1'b0, coef});
		scaled = prod >>> COEF_FRAC;
		// Clip to sample range
		if (scaled[PROD_W-1:SAMPLE_W-1] == '0 || scaled[PROD_W-1:SAMPLE_W-1] == '1) begin
			data_next = scaled[SAMPLE_W-1:0];
		end else begin
			data_next = {scaled[PROD_W-1], {(SAMPLE_W-1){~scaled[PROD_W-1]}}};
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			data_o <= '0;
			valid_o <= 1'b0;
		end else begin
			data_o <= data_next;
			valid_o <= valid_i;
		end
	end
endmodule // cdgo_chan_apply
`default_nettype wire

// [src/cdgo_regs.sv]
// APB register bank for channel 2/3 digital gain and offset, with sample paths
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cdgo_regs #(
	parameter int SAMPLE_W = 14
) (
	input wire logic CLK_I, // 100 MHz clock
	input wire logic SRST_I, // Synchronous reset, high
	input wire logic PSEL_I, // APB select
	input wire logic PENABLE_I, // APB access phase
	input wire logic PWRITE_I, // APB write
	input wire logic [cdgo_pkg::ADDR_W-1:0] PADDR_I, // APB byte address
	input wire logic [cdgo_pkg::DATA_W-1:0] PWDATA_I, // APB write data
	input wire logic [3:0] PSTRB_I, // APB byte strobes
	output logic [cdgo_pkg::DATA_W-1:0] PRDATA_O, // APB read data
	output logic PREADY_O, // APB ready
	output logic PSLVERR_O, // APB error, unmapped address
	input wire logic signed [SAMPLE_W-1:0] CH2_DATA_I, // Channel 2 sample
	input wire logic CH2_VALID_I, // Channel 2 sample valid
	input wire logic signed [SAMPLE_W-1:0] CH3_DATA_I, // Channel 3 sample
	input wire logic CH3_VALID_I, // Channel 3 sample valid
	output logic signed [SAMPLE_W-1:0] CH2_DATA_O, // Channel 2 result
	output logic CH2_VALID_O, // Channel 2 result valid
	output logic signed [SAMPLE_W-1:0] CH3_DATA_O, // Channel 3 result
	output logic CH3_VALID_O // Channel 3 result valid
);
	import cdgo_pkg::*;

	generate
		if (SAMPLE_W < 10 || SAMPLE_W > 24) begin : g_bad_width
			$error("SAMPLE_W must lie between 10 and 24");
		end
	endgenerate

	logic [REG_W-1:0] ctrl_reg;
	logic [REG_W-1:0] ch2_gain_offset_reg;
	logic [REG_W-1:0] ch2_offset_copy_reg;
	logic [REG_W-1:0] ch3_gain_offset_reg;
	logic [REG_W-1:0] ch3_offset_copy_reg;
	logic [1:0] mismatch_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [DATA_W-1:0] prdata_reg;

	logic access;
	logic wr_fire;
	logic hit_ctrl;
	logic hit_ch2_go;
	logic hit_ch2_oc;
	logic hit_ch3_go;
	logic hit_ch3_oc;
	logic hit_status;
	logic mapped;
	logic [DATA_W-1:0] rdata_next;
	logic [1:0] mismatch_next;
	logic digital_gain_enable;
	logic digital_offset_enable;
	logic [4:0] second_channel_gain_steps;
	logic [4:0] third_channel_gain_steps;
	logic [9:0] second_channel_offset_value;
	logic [9:0] third_channel_offset_value;

	// Address compare against a register index
	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
		return addr == {idx, 2'b00};
	endfunction

	// Byte-lane merge of a 16-bit register
	function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
		input logic [DATA_W-1:0] wd, input logic [3:0] strb);
		logic [REG_W-1:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	always_comb begin
		hit_ctrl = addr_hit(PADDR_I, CTRL_IDX);
		hit_ch2_go = addr_hit(PADDR_I, CH2_GAIN_OFFSET_IDX);
		hit_ch2_oc = addr_hit(PADDR_I, CH2_OFFSET_COPY_IDX);
		hit_ch3_go = addr_hit(PADDR_I, CH3_GAIN_OFFSET_IDX);
		hit_ch3_oc = addr_hit(PADDR_I, CH3_OFFSET_COPY_IDX);
		hit_status = addr_hit(PADDR_I, STATUS_IDX);
		mapped = hit_ctrl | hit_ch2_go | hit_ch2_oc | hit_ch3_go | hit_ch3_oc | hit_status;
		access = PSEL_I & PENABLE_I;
		// Write lands on the edge that completes the transfer
		wr_fire = access & PWRITE_I & pready_reg & mapped;
	end

	always_comb begin
		rdata_next = '0;
		if (hit_ctrl) begin
			rdata_next[REG_W-1:0] = ctrl_reg;
		end else if (hit_ch2_go) begin
			rdata_next[REG_W-1:0] = ch2_gain_offset_reg;
		end else if (hit_ch2_oc) begin
			rdata_next[REG_W-1:0] = ch2_offset_copy_reg;
		end else if (hit_ch3_go) begin
			rdata_next[REG_W-1:0] = ch3_gain_offset_reg;
		end else if (hit_ch3_oc) begin
			rdata_next[REG_W-1:0] = ch3_offset_copy_reg;
		end else if (hit_status) begin
			rdata_next[ST_CH2_MISMATCH_BIT] = mismatch_reg[0];
			rdata_next[ST_CH3_MISMATCH_BIT] = mismatch_reg[1];
		end
	end

	// APB handshake: one wait state, then ready
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			pready_reg <= access & ~pready_reg;
			pslverr_reg <= access & ~pready_reg & ~mapped;
			if (access & ~pready_reg & ~PWRITE_I) begin
				prdata_reg <= rdata_next;
			end else if (pready_reg) begin
				prdata_reg <= '0;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_fire & hit_ctrl) begin
			ctrl_reg <= merge(ctrl_reg, PWDATA_I, PSTRB_I);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ch2_gain_offset_reg <= GAIN_OFFSET_RESET;
			ch2_offset_copy_reg <= OFFSET_COPY_RESET;
		end else begin
			if (wr_fire & hit_ch2_go) begin
				ch2_gain_offset_reg <= merge(ch2_gain_offset_reg, PWDATA_I, PSTRB_I);
			end
			if (wr_fire & hit_ch2_oc) begin
				ch2_offset_copy_reg <= merge(ch2_offset_copy_reg, PWDATA_I, PSTRB_I);
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ch3_gain_offset_reg <= GAIN_OFFSET_RESET;
			ch3_offset_copy_reg <= OFFSET_COPY_RESET;
		end else begin
			if (wr_fire & hit_ch3_go) begin
				ch3_gain_offset_reg <= merge(ch3_gain_offset_reg, PWDATA_I, PSTRB_I);
			end
			if (wr_fire & hit_ch3_oc) begin
				ch3_offset_copy_reg <= merge(ch3_offset_copy_reg, PWDATA_I, PSTRB_I);
			end
		end
	end

	always_comb begin
		mismatch_next[0] = ch2_gain_offset_reg[OFFSET_MSB:OFFSET_LSB]
			!= ch2_offset_copy_reg[OFFSET_MSB:OFFSET_LSB];
		mismatch_next[1] = ch3_gain_offset_reg[OFFSET_MSB:OFFSET_LSB]
			!= ch3_offset_copy_reg[OFFSET_MSB:OFFSET_LSB];
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			mismatch_reg <= 2'b00;
		end else begin
			mismatch_reg <= mismatch_next;
		end
	end

	always_comb begin
		digital_gain_enable = ctrl_reg[GAIN_EN_BIT];
		digital_offset_enable = ctrl_reg[OFFSET_EN_BIT];
		second_channel_gain_steps = ch2_gain_offset_reg[GAIN_MSB:GAIN_LSB];
		third_channel_gain_steps = ch3_gain_offset_reg[GAIN_MSB:GAIN_LSB];
		second_channel_offset_value = ch2_gain_offset_reg[OFFSET_MSB:OFFSET_LSB];
		third_channel_offset_value = ch3_gain_offset_reg[OFFSET_MSB:OFFSET_LSB];
	end

	cdgo_chan_apply #(
		.SAMPLE_W(SAMPLE_W)
	) u_ch2 (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.gain_steps_i(second_channel_gain_steps),
		.offset_i(second_channel_offset_value),
		.gain_en_i(digital_gain_enable),
		.offset_en_i(digital_offset_enable),
		.data_i(CH2_DATA_I),
		.valid_i(CH2_VALID_I),
		.data_o(CH2_DATA_O),
		.valid_o(CH2_VALID_O)
	);

	cdgo_chan_apply #(
		.SAMPLE_W(SAMPLE_W)
	) u_ch3 (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.gain_steps_i(third_channel_gain_steps),
		.offset_i(third_channel_offset_value),
		.gain_en_i(digital_gain_enable),
		.offset_en_i(digital_offset_enable),
		.data_i(CH3_DATA_I),
		.valid_i(CH3_VALID_I),
		.data_o(CH3_DATA_O),
		.valid_o(CH3_VALID_O)
	);

	always_comb begin
		PRDATA_O = prdata_reg;
		PREADY_O = pready_reg;
		PSLVERR_O = pslverr_reg;
	end
endmodule // cdgo_regs
`default_nettype wire

// [tb/cdgo_regs_monitor.sv]
// Bus and sample timing checker for the gain and offset bank
`timescale 1ns/1ns
`default_nettype none
module cdgo_regs_monitor (
	input wire logic CLK_I, // Clock
	input wire logic SRST_I, // Reset
	input wire logic PSEL_I, // Select
	input wire logic PENABLE_I, // Access phase
	input wire logic [cdgo_pkg::DATA_W-1:0] PRDATA_O, // Read data
	input wire logic PREADY_O, // Ready
	input wire logic PSLVERR_O, // Error
	input wire logic CH2_VALID_I, // Ch2 in valid
	input wire logic CH3_VALID_I, // Ch3 in valid
	input wire logic CH2_VALID_O, // Ch2 out valid
	input wire logic CH3_VALID_O // Ch3 out valid
);
	import cdgo_pkg::*;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_access;
		PSEL_I && PENABLE_I;
	endsequence
	a_one_wait: assert property (s_setup ##1 s_access |=> PREADY_O)
		else $error("ready missing after one wait state");
	a_no_early: assert property (s_setup |=> !PREADY_O)
		else $error("ready too early");
	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (PREADY_O |-> s_access and $past(PENABLE_I))
		else $error("ready without access phase");
	a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0000_0000)
		else $error("read data outside answer");
	a_rdata_upper: assert property (PREADY_O |-> PRDATA_O[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_ch2_latency: assert property (CH2_VALID_I |=> CH2_VALID_O)
		else $error("ch2 result late");
	a_ch3_latency: assert property (!CH3_VALID_I |=> !CH3_VALID_O)
		else $error("ch3 result without sample");
endmodule // cdgo_regs_monitor
`default_nettype wire

// [tb/tb_cdgo_regs.sv]
// Self-checking bench for the gain and offset register bank
`timescale 1ns/1ns
`default_nettype none
module tb_cdgo_regs;
	import cdgo_pkg::*;
	logic CLK_I = 1'b0, SRST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
	logic [7:0] PADDR_I = 8'h00;
	logic [31:0] PWDATA_I = 32'h0000_0000, PRDATA_O;
	logic [3:0] PSTRB_I = 4'hf;
	logic PREADY_O, PSLVERR_O, CH2_VALID_I = 1'b0, CH3_VALID_I = 1'b0, CH2_VALID_O, CH3_VALID_O;
	logic signed [13:0] CH2_DATA_I = 14'h0000, CH3_DATA_I = 14'h0000, CH2_DATA_O, CH3_DATA_O;
	int bad_count = 0, total_checks = 0, seed = 32'hbbd1_cc25;
	int g2, o2, g3, o3, ge, oe;
	logic [33:0] qa[$];
	logic [33:0] ea;
	int q2[$], q3[$];
	cdgo_regs dut_u (.CLK_I, .SRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
		.PSTRB_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .CH2_DATA_I, .CH2_VALID_I, .CH3_DATA_I,
		.CH3_VALID_I, .CH2_DATA_O, .CH2_VALID_O, .CH3_DATA_O, .CH3_VALID_O);
	always #5 CLK_I = ~CLK_I;
	task check(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask
	task test_done();
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic int f(int d, int g, int o);
		longint x;
		x = d + (oe ? o : 0);
		x = (x * (ge ? $rtoi(16384.0 * 10.0 ** (g * 0.01) + 0.5) : 16384)) >>> 14;
		if (x > 8191) x = 8191;
		if (x < -8192) x = -8192;
		return int'(x);
	endfunction
	task apb(input logic w, input logic [5:0] i, input logic [31:0] d, input logic er,
		input logic [31:0] e);
		qa.push_back({w, er, e});
		@(posedge CLK_I);
		PSEL_I <= 1'b1;
		PENABLE_I <= 1'b0;
		PWRITE_I <= w;
		PADDR_I <= {i, 2'b00};
		PWDATA_I <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		do @(posedge CLK_I); while (PREADY_O !== 1'b1);
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask
	task wr(input logic [5:0] i, input logic [31:0] d);
		apb(1'b1, i, d, 1'b0, 32'h0000_0000);
		apb(1'b0, i, 32'h0000_0000, 1'b0, d);
	endtask
	task smp();
		int d2, d3;
		d2 = $random(seed) % 8192;
		d3 = $random(seed) % 8192;
		q2.push_back(f(d2, g2, o2));
		q3.push_back(f(d3, g3, o3));
		@(posedge CLK_I);
		CH2_DATA_I <= d2[13:0];
		CH3_DATA_I <= d3[13:0];
		CH2_VALID_I <= 1'b1;
		CH3_VALID_I <= 1'b1;
	endtask
	always @(posedge CLK_I) begin
		if (PREADY_O === 1'b1) begin
			ea = qa.pop_front();
			check({31'h0000_0000, PSLVERR_O}, {31'h0000_0000, ea[32]});
			if (!ea[33]) check(PRDATA_O, ea[31:0]);
		end
		if (CH2_VALID_O === 1'b1) check(32'(CH2_DATA_O), q2.pop_front());
		if (CH3_VALID_O === 1'b1) check(32'(CH3_DATA_O), q3.pop_front());
	end
	initial begin
		repeat (20000) @(posedge CLK_I);
		bad_count++;
		test_done();
	end
	initial begin
		repeat (5) @(posedge CLK_I);
		SRST_I <= 1'b0;
		for (int i = 15; i <= 18; i++) apb(1'b0, 6'(i), 32'h0000_0000, 1'b0, 32'h0000_0000);
		apb(1'b0, 6'h00, 32'h0000_0000, 1'b1, 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			ge = k % 2;
			oe = k / 2;
			g2 = {$random(seed)} % 32;
			g3 = {$random(seed)} % 32;
			o2 = $random(seed) % 512;
			o3 = $random(seed) % 512;
			if (k == 3) begin
				g2 = 31;
				o3 = -512;
			end
			wr(CTRL_IDX, 32'(ge << GAIN_EN_BIT | oe << OFFSET_EN_BIT));
			wr(CH2_GAIN_OFFSET_IDX, {16'h0000, g2[4:0], 1'b0, o2[9:0]});
			wr(CH2_OFFSET_COPY_IDX, {22'h00_0000, o2[9:0]});
			wr(CH3_GAIN_OFFSET_IDX, {16'h0000, g3[4:0], 1'b0, o3[9:0]});
			wr(CH3_OFFSET_COPY_IDX, {22'h00_0000, o3[9:0]});
			apb(1'b0, STATUS_IDX, 32'h0000_0000, 1'b0, 32'h0000_0000);
			repeat (4) smp();
			@(posedge CLK_I);
			CH2_VALID_I <= 1'b0;
			CH3_VALID_I <= 1'b0;
			repeat (2) @(posedge CLK_I);
		end
		// Mid-run reset clears every register
		SRST_I <= 1'b1;
		repeat (2) @(posedge CLK_I);
		SRST_I <= 1'b0;
		for (int i = 15; i <= 18; i++) apb(1'b0, 6'(i), 32'h0000_0000, 1'b0, 32'h0000_0000);
		apb(1'b0, CTRL_IDX, 32'h0000_0000, 1'b0, 32'h0000_0000);
		// Byte lanes, then unequal copies raise the status flags
		PSTRB_I <= 4'h2;
		apb(1'b1, CH2_GAIN_OFFSET_IDX, 32'h0000_ABCD, 1'b0, 32'h0000_0000);
		PSTRB_I <= 4'h1;
		apb(1'b1, CH2_GAIN_OFFSET_IDX, 32'h0000_12C3, 1'b0, 32'h0000_0000);
		PSTRB_I <= 4'hf;
		apb(1'b0, CH2_GAIN_OFFSET_IDX, 32'h0000_0000, 1'b0, 32'h0000_ABC3);
		wr(CH3_OFFSET_COPY_IDX, 32'h0000_0155);
		apb(1'b1, STATUS_IDX, 32'h0000_0000, 1'b0, 32'h0000_0000);
		apb(1'b0, STATUS_IDX, 32'h0000_0000, 1'b0, 32'h0000_0003);
		apb(1'b1, 6'h01, 32'h0000_FFFF, 1'b1, 32'h0000_0000);
		wr(CH2_OFFSET_COPY_IDX, 32'h0000_03C3);
		wr(CH3_OFFSET_COPY_IDX, 32'h0000_0000);
		apb(1'b0, STATUS_IDX, 32'h0000_0000, 1'b0, 32'h0000_0000);
		repeat (2) @(posedge CLK_I);
		test_done();
	end
endmodule // tb_cdgo_regs
bind cdgo_regs cdgo_regs_monitor mon_u (.CLK_I, .SRST_I, .PSEL_I, .PENABLE_I, .PRDATA_O,
	.PREADY_O, .PSLVERR_O, .CH2_VALID_I, .CH3_VALID_I, .CH2_VALID_O, .CH3_VALID_O);
`default_nettype wire
